// ==== rtl/cfe_pkg.sv ====
// Constants and types of the fetch/execute control core.
// Assumes one clock in which each rising edge is one phase of a cycle.
package cfe_pkg;
    localparam int PC_MAX_W = 11;
    localparam int INSN_W   = 12;
    localparam int DATA_W   = 8;
    localparam int FADDR_W  = 7;
    // Field positions of the instruction word, PC and file select
    localparam int OPC_HI   = 11;
    localparam int OPC_LO   = 6;
    localparam int GRP_LO   = 8;
    localparam int JMP_LO   = 9;
    localparam int DEST_BIT = 5;
    localparam int FILE_HI  = 4;
    localparam int BIT_HI   = 7;
    localparam int BIT_LO   = 5;
    localparam int LIT_HI   = 7;
    localparam int JLIT_HI  = 8;
    localparam int PAGE_BIT = 9;
    localparam int BANK_HI  = 6;
    localparam int BANK_LO  = 5;
    // Special file addresses
    localparam logic [4:0] FILE_INDIRECT = 5'h00;
    localparam logic [4:0] FILE_PCL      = 5'h02;
    // Byte-oriented opcodes, word bits 11..6
    localparam logic [5:0] OP_MISC   = 6'h00;
    localparam logic [5:0] OP_SUBWF  = 6'h02;
    localparam logic [5:0] OP_DECF   = 6'h03;
    localparam logic [5:0] OP_IORWF  = 6'h04;
    localparam logic [5:0] OP_ANDWF  = 6'h05;
    localparam logic [5:0] OP_XORWF  = 6'h06;
    localparam logic [5:0] OP_ADDWF  = 6'h07;
    localparam logic [5:0] OP_MOVF   = 6'h08;
    localparam logic [5:0] OP_COMF   = 6'h09;
    localparam logic [5:0] OP_INCF   = 6'h0a;
    localparam logic [5:0] OP_DECFSZ = 6'h0b;
    localparam logic [5:0] OP_RRF    = 6'h0c;
    localparam logic [5:0] OP_RLF    = 6'h0d;
    localparam logic [5:0] OP_SWAPF  = 6'h0e;
    localparam logic [5:0] OP_INCFSZ = 6'h0f;
    localparam logic [5:0] OP_CLRWF  = 6'h01;
    // Bit-oriented and literal opcodes, word bits 11..8 (OP_JUMP: bits 11..9)
    localparam logic [3:0] OP_BCF    = 4'h4;
    localparam logic [3:0] OP_BSF    = 4'h5;
    localparam logic [3:0] OP_BTFSC  = 4'h6;
    localparam logic [3:0] OP_BTFSS  = 4'h7;
    localparam logic [3:0] OP_RETLW  = 4'h8;
    localparam logic [3:0] OP_CALL   = 4'h9;
    localparam logic [3:0] OP_MOVLW  = 4'hc;
    localparam logic [3:0] OP_IORLW  = 4'hd;
    localparam logic [3:0] OP_ANDLW  = 4'he;
    localparam logic [3:0] OP_XORLW  = 4'hf;
    localparam logic [2:0] OP_JUMP   = 3'h5;
    localparam logic [1:0] CLASS_BYTE = 2'h0;
    localparam logic [1:0] CLASS_BIT  = 2'h1;
    localparam logic [6:0] MOVWF_HI   = 7'h01;
    localparam logic [6:0] CLRF_HI    = 7'h03;
    localparam logic [INSN_W-1:0] WORD_CLRW = 12'h040;
    localparam logic [INSN_W-1:0] WORD_NOP  = 12'h000;

    typedef enum logic [3:0] {
        PH_ONE   = 4'h1,
        PH_TWO   = 4'h2,
        PH_THREE = 4'h4,
        PH_FOUR  = 4'h8
    } cfe_phase_t;

    typedef struct packed {
        cfe_phase_t                 phase;
        logic [PC_MAX_W-1:0]        pc;
        logic [PC_MAX_W-1:0]        fetch_addr;
        logic [INSN_W-1:0]          fetch_word;
        logic                       fetch_ok;
        logic [INSN_W-1:0]          ir;
        logic                       ir_ok;
        logic [FADDR_W-1:0]         faddr;
        logic [DATA_W-1:0]          operand;
        logic [DATA_W-1:0]          result;
        logic [DATA_W-1:0]          w;
    } cfe_state_t;
endpackage

// ==== rtl/cfe_core.sv ====
// Fetch/execute control core: phase generator, two-stage pipeline,
// program counter and instruction decode for an 8-bit core.
// Assumes program memory answers combinationally on o_prog_addr and
// the register file answers combinationally on o_file_addr.
module cfe_core
    import cfe_pkg::*;
#(
    parameter int PC_W = 11
) (
    input  wire logic                i_clock,
    input  wire logic                i_rstn,
    input  wire logic [INSN_W-1:0]   i_prog_data,
    input  wire logic [DATA_W-1:0]   i_file_rdata,
    input  wire logic [DATA_W-1:0]   i_file_select,
    input  wire logic [1:0]          i_status_page,
    input  wire logic                i_carry,
    output logic                     o_phase_one,
    output logic                     o_phase_two,
    output logic                     o_phase_three,
    output logic                     o_phase_four,
    output logic [PC_MAX_W-1:0]      o_prog_addr,
    output logic [FADDR_W-1:0]       o_file_addr,
    output logic                     o_file_rd,
    output logic                     o_file_wr,
    output logic [DATA_W-1:0]        o_file_wdata,
    output logic [DATA_W-1:0]        o_working,
    output logic [INSN_W-1:0]        o_instruction,
    output logic                     o_exec_valid
);
    // Mask of the implemented program space
    localparam logic [PC_MAX_W-1:0] PC_MASK =
        PC_MAX_W'((1 << PC_W) - 1);

    cfe_state_t s_q;
    cfe_state_t s_d;

    function automatic logic [PC_MAX_W-1:0] pc_wrap(
        input logic [PC_MAX_W-1:0] a
    );
        return a & PC_MASK;
    endfunction

    function automatic logic [1:0] insn_class(
        input logic [INSN_W-1:0] word
    );
        return word[OPC_HI -: 2];
    endfunction

    function automatic logic [FADDR_W-1:0] file_target(
        input logic [INSN_W-1:0] word,
        input logic [DATA_W-1:0] fsel
    );
        logic [4:0] f;
        f = word[FILE_HI:0];
        if (f == FILE_INDIRECT) begin
            return fsel[FADDR_W-1:0];
        end
        return {fsel[BANK_HI:BANK_LO], f};
    endfunction

    // Decoded fields of the executing word
    logic [5:0]        opc;
    logic [3:0]        grp;
    logic [1:0]        cls;
    logic              dest_file;
    logic [2:0]        bit_sel;
    logic [7:0]        lit;
    logic [8:0]        jlit;
    logic [DATA_W-1:0] bit_mask;
    logic              to_file;
    logic              to_w;
    logic              is_jump;
    logic              is_call;
    logic              is_skip;
    logic              pcl_write;
    logic              flush;
    logic [PC_MAX_W-1:0] pc_target;
    logic [DATA_W-1:0] alu;

    always_comb begin
        opc       = s_q.ir[OPC_HI:OPC_LO];
        grp       = s_q.ir[OPC_HI:GRP_LO];
        cls       = insn_class(s_q.ir);
        dest_file = s_q.ir[DEST_BIT];
        bit_sel   = s_q.ir[BIT_HI:BIT_LO];
        lit       = s_q.ir[LIT_HI:0];
        jlit      = s_q.ir[JLIT_HI:0];
        bit_mask  = 8'h01 << bit_sel;
        is_jump   = s_q.ir_ok && s_q.ir[OPC_HI:JMP_LO] == OP_JUMP;
        is_call   = s_q.ir_ok && grp == OP_CALL;
        to_file   = 1'b0;
        to_w      = 1'b0;
        is_skip   = 1'b0;
        alu       = s_q.operand;
        if (cls == CLASS_BYTE) begin
            to_file = dest_file;
            to_w    = !dest_file;
            case (opc)
                OP_MISC, OP_CLRWF: begin
                    to_file = s_q.ir[OPC_HI:DEST_BIT] == MOVWF_HI
                           || s_q.ir[OPC_HI:DEST_BIT] == CLRF_HI;
                    to_w    = s_q.ir == WORD_CLRW;
                    alu     = (s_q.ir[OPC_HI:DEST_BIT] == MOVWF_HI)
                            ? s_q.w : 8'h00;
                end
                OP_SUBWF:  alu = s_q.operand - s_q.w;
                OP_DECF:   alu = s_q.operand - 8'h01;
                OP_IORWF:  alu = s_q.operand | s_q.w;
                OP_ANDWF:  alu = s_q.operand & s_q.w;
                OP_XORWF:  alu = s_q.operand ^ s_q.w;
                OP_ADDWF:  alu = s_q.operand + s_q.w;
                OP_MOVF:   alu = s_q.operand;
                OP_COMF:   alu = ~s_q.operand;
                OP_INCF:   alu = s_q.operand + 8'h01;
                OP_DECFSZ: alu = s_q.operand - 8'h01;
                OP_RRF:    alu = {i_carry, s_q.operand[7:1]};
                OP_RLF:    alu = {s_q.operand[6:0], i_carry};
                OP_SWAPF:  alu = {s_q.operand[3:0], s_q.operand[7:4]};
                OP_INCFSZ: alu = s_q.operand + 8'h01;
                default:   alu = s_q.operand;
            endcase
        end else if (cls == CLASS_BIT) begin
            case (grp)
                OP_BCF: begin
                    alu     = s_q.operand & ~bit_mask;
                    to_file = 1'b1;
                end
                OP_BSF: begin
                    alu     = s_q.operand | bit_mask;
                    to_file = 1'b1;
                end
                default: alu = s_q.operand;
            endcase
        end else begin
            to_w = 1'b1;
            case (grp)
                OP_MOVLW: alu = lit;
                OP_RETLW: alu = lit;
                OP_IORLW: alu = s_q.w | lit;
                OP_ANDLW: alu = s_q.w & lit;
                OP_XORLW: alu = s_q.w ^ lit;
                default: begin
                    alu  = s_q.w;
                    to_w = 1'b0;
                end
            endcase
        end
        // DECFSZ/INCFSZ skips look at the finished result, bit tests at the operand
        case (opc)
            OP_DECFSZ, OP_INCFSZ: is_skip = s_q.result == 8'h00;
            default: begin
                if (grp == OP_BTFSC) begin
                    is_skip = (s_q.operand & bit_mask) == 8'h00;
                end else if (grp == OP_BTFSS) begin
                    is_skip = (s_q.operand & bit_mask) != 8'h00;
                end
            end
        endcase
        // A flushed word has no effect anywhere
        to_file   = to_file && s_q.ir_ok;
        to_w      = to_w && s_q.ir_ok;
        is_skip   = is_skip && s_q.ir_ok;
        pcl_write = to_file
                 && s_q.ir[FILE_HI:0] == FILE_PCL;
        if (is_jump) begin
            pc_target = {i_status_page[1], jlit[8], 1'b0, lit};
            pc_target[PAGE_BIT] = i_status_page[0];
            pc_target[JLIT_HI]  = jlit[8];
        end else if (is_call) begin
            pc_target = {i_status_page, 1'b0, lit};
        end else begin
            pc_target = {i_status_page, 1'b0, s_q.result};
        end
        flush = is_jump || is_call || pcl_write || is_skip;
    end

    always_comb begin
        s_d = s_q;
        case (s_q.phase)
            PH_ONE: begin
                s_d.phase      = PH_TWO;
                s_d.fetch_addr = s_q.pc;
                s_d.pc         = pc_wrap(s_q.pc + 11'h001);
                s_d.ir         = s_q.fetch_word;
                s_d.ir_ok      = s_q.fetch_ok;
                s_d.faddr      = file_target(s_q.fetch_word,
                                             i_file_select);
            end
            PH_TWO: begin
                s_d.phase   = PH_THREE;
                s_d.operand = i_file_rdata;
            end
            PH_THREE: begin
                s_d.phase  = PH_FOUR;
                s_d.result = alu;
            end
            PH_FOUR: begin
                s_d.phase      = PH_ONE;
                s_d.fetch_word = i_prog_data;
                s_d.fetch_ok   = !flush;
                if (flush && !is_skip) begin
                    s_d.pc = pc_wrap(pc_target);
                end
                if (to_w) begin
                    s_d.w = s_q.result;
                end
            end
            default: s_d.phase = PH_ONE;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            s_q            <= '0;
            s_q.phase      <= PH_ONE;
            s_q.pc         <= PC_MASK;
            s_q.fetch_addr <= PC_MASK;
            s_q.fetch_word <= WORD_NOP;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_phase_one   = s_q.phase == PH_ONE;
    assign o_phase_two   = s_q.phase == PH_TWO;
    assign o_phase_three = s_q.phase == PH_THREE;
    assign o_phase_four  = s_q.phase == PH_FOUR;
    assign o_prog_addr   = s_q.fetch_addr;
    assign o_file_addr   = s_q.faddr;
    assign o_file_rd     = o_phase_two && s_q.ir_ok;
    assign o_file_wr     = o_phase_four && to_file;
    assign o_file_wdata  = s_q.result;
    assign o_working     = s_q.w;
    assign o_instruction = s_q.ir;
    assign o_exec_valid  = s_q.ir_ok;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);

    a_phase_onehot: assert property ($onehot(s_q.phase))
        else $error("Phase is not one-hot");
    a_phase_order: assert property (
        i_rstn && o_phase_one
            |=> o_phase_two ##1 o_phase_three ##1 o_phase_four)
        else $error("Phase sequence broken");
    a_pc_advance: assert property (
        i_rstn && o_phase_one |=> s_q.pc == pc_wrap($past(s_q.pc) + 11'h001))
        else $error("PC did not advance in phase one");
    a_fetch_capture: assert property (
        o_phase_four |=> s_q.fetch_word == $past(i_prog_data))
        else $error("Fetched word not captured");
    a_ir_load: assert property (
        o_phase_one |=> s_q.ir == $past(s_q.fetch_word)
                     && s_q.ir_ok == $past(s_q.fetch_ok))
        else $error("Instruction register not loaded");
    a_read_write: assert property (
        (o_file_rd |-> o_phase_two) and (o_file_wr |-> o_phase_four))
        else $error("File access in wrong phase");
    a_jump_flush: assert property (
        o_phase_four && is_jump |=> o_phase_one && !s_q.fetch_ok
            ##1 !s_q.ir_ok ##2 !o_file_wr)
        else $error("Jump did not flush prefetch");
    a_pc_wrap: assert property ((s_q.pc & ~PC_MASK) == '0)
        else $error("PC beyond implemented size");
    a_bit8_clear: assert property (
        o_phase_four && (is_call || pcl_write) |=> !s_q.pc[JLIT_HI])
        else $error("PC bit eight not cleared");
    a_dest_working: assert property (
        o_phase_four && to_w && !to_file |=> s_q.w == $past(s_q.result))
        else $error("Working register not written");
    a_flush_quiet: assert property (
        !s_q.ir_ok |-> !o_file_wr && !o_file_rd)
        else $error("Flushed word had side effects");
    a_fetch_addr: assert property (
        i_rstn && o_phase_one |=> o_prog_addr == $past(s_q.pc))
        else $error("Fetch address not taken from PC");
    a_addr_stable: assert property (
        !o_phase_one |=> $stable(o_prog_addr))
        else $error("Fetch address moved inside cycle");
    a_ir_stable: assert property (
        !o_phase_one |=> $stable(s_q.ir) && $stable(s_q.ir_ok))
        else $error("Instruction register moved mid-cycle");
    a_operand_read: assert property (
        o_file_rd |=> s_q.operand == $past(i_file_rdata))
        else $error("Operand not read in phase two");
    a_result_hold: assert property (
        !o_phase_three |=> $stable(s_q.result))
        else $error("Result moved outside phase three");
    a_one_per_cycle: assert property (
        o_phase_four && !flush |=> s_q.fetch_ok)
        else $error("Fetched word dropped without flush");
    a_skip_flush: assert property (
        o_phase_four && is_skip |=> !s_q.fetch_ok
            && s_q.pc == $past(s_q.pc))
        else $error("Skip did not discard next word");
    a_jump_target: assert property (
        o_phase_four && is_jump |=> s_q.pc
            == pc_wrap($past({i_status_page, s_q.ir[JLIT_HI:0]})))
        else $error("Jump did not load its target");
    a_call_target: assert property (
        o_phase_four && is_call |=> s_q.pc
            == pc_wrap($past({i_status_page, 1'b0, s_q.ir[LIT_HI:0]})))
        else $error("Call did not load its target");
    a_file_direct: assert property (
        o_phase_two && s_q.ir[FILE_HI:0] != FILE_INDIRECT
            |-> o_file_addr[FILE_HI:0] == s_q.ir[FILE_HI:0])
        else $error("Direct file address wrong");
    a_file_indirect: assert property (
        o_phase_two && s_q.ir[FILE_HI:0] == FILE_INDIRECT
            |-> o_file_addr == $past(i_file_select[FADDR_W-1:0]))
        else $error("Indirect file address wrong");
    a_bank_select: assert property (
        o_phase_two && s_q.ir[FILE_HI:0] != FILE_INDIRECT
            |-> o_file_addr[FADDR_W-1:FILE_HI+1]
                == $past(i_file_select[BANK_HI:BANK_LO]))
        else $error("Bank bits not taken from file select");
    a_dest_file: assert property (
        o_phase_four && s_q.ir_ok && cls == CLASS_BYTE
            |-> o_file_wr == dest_file)
        else $error("Destination bit not obeyed");
    a_literal_load: assert property (
        o_phase_four && s_q.ir_ok && grp == OP_MOVLW
            |=> s_q.w == $past(s_q.ir[LIT_HI:0]))
        else $error("Literal not loaded into working");
    a_bit_set: assert property (
        o_file_wr && grp == OP_BSF
            |-> o_file_wdata[s_q.ir[BIT_HI:BIT_LO]])
        else $error("Chosen bit not set");
    a_vector_wrap: assert property (
        i_rstn && o_phase_one && s_q.pc == PC_MASK |=> s_q.pc == '0)
        else $error("PC did not wrap to zero");
endmodule

// ==== tb/cfe_mem_model.sv ====
// Program memory and register file seen by the control core.
// Assumes the bench fills prog while the core is held in reset.
module cfe_mem_model
    import cfe_pkg::*;
(
    input  wire logic                i_clock,
    input  wire logic [PC_MAX_W-1:0] i_prog_addr,
    input  wire logic [FADDR_W-1:0]  i_file_addr,
    input  wire logic                i_file_rd,
    input  wire logic                i_file_wr,
    input  wire logic [DATA_W-1:0]   i_file_wdata,
    output logic      [INSN_W-1:0]   o_prog_data,
    output logic      [DATA_W-1:0]   o_file_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [INSN_W-1:0] prog [2**PC_MAX_W];
    logic [DATA_W-1:0] regs [2**FADDR_W];
    assign o_prog_data = prog[i_prog_addr];
    // Scrambled byte while no read strobe
    assign o_file_rdata = i_file_rd ? regs[i_file_addr] : ~regs[i_file_addr];
    always @(posedge i_clock) begin
        if (i_file_wr === 1'b1) begin
            regs[i_file_addr] <= i_file_wdata;
        end
    end
    initial begin
        for (int i = 0; i < 2**FADDR_W; i++) begin
            regs[i] = 8'h00;
        end
    end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the fetch/execute control core.
// Assumes the memory model answers combinationally.
module testbench;
    import cfe_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic                i_clock;
    logic                i_rstn;
    logic [DATA_W-1:0]   i_file_select;
    logic [1:0]          i_status_page;
    logic                i_carry;
    logic [INSN_W-1:0]   prog_data;
    logic [DATA_W-1:0]   file_rdata;
    logic                o_phase_one;
    logic                o_phase_two;
    logic                o_phase_three;
    logic                o_phase_four;
    logic [PC_MAX_W-1:0] o_prog_addr;
    logic [FADDR_W-1:0]  o_file_addr;
    logic                o_file_rd;
    logic                o_file_wr;
    logic [DATA_W-1:0]   o_file_wdata;
    logic [DATA_W-1:0]   o_working;
    logic [INSN_W-1:0]   o_instruction;
    logic                o_exec_valid;
    logic [31:0]         seed = 32'hb3dbff41;
    int                  n_fail;
    int                  num_checks;
    int                  cyc;
    logic                logging;
    logic [3:0]          ph_prev;
    logic [PC_MAX_W-1:0] addr_q [$];
    logic [INSN_W-1:0]   word_q [$];
    logic [14:0]         wr_q   [$];

    cfe_core #(.PC_W(11)) cfe_core_i (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_prog_data(prog_data),
        .i_file_rdata(file_rdata), .i_file_select(i_file_select),
        .i_status_page(i_status_page), .i_carry(i_carry),
        .o_phase_one(o_phase_one), .o_phase_two(o_phase_two),
        .o_phase_three(o_phase_three), .o_phase_four(o_phase_four),
        .o_prog_addr(o_prog_addr), .o_file_addr(o_file_addr),
        .o_file_rd(o_file_rd), .o_file_wr(o_file_wr),
        .o_file_wdata(o_file_wdata), .o_working(o_working),
        .o_instruction(o_instruction), .o_exec_valid(o_exec_valid));
    cfe_mem_model cfe_mem_model_i (
        .i_clock(i_clock), .i_prog_addr(o_prog_addr),
        .i_file_addr(o_file_addr), .i_file_rd(o_file_rd),
        .i_file_wr(o_file_wr), .i_file_wdata(o_file_wdata),
        .o_prog_data(prog_data), .o_file_rdata(file_rdata));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    // Fetch order: vector, 0..7, then jump target onwards
    function automatic logic [PC_MAX_W-1:0] exp_fetch(input int i,
        input logic [PC_MAX_W-1:0] t);
        if (i == 0) return 11'h7ff;
        if (i <= 8) return PC_MAX_W'(i - 1);
        return t + PC_MAX_W'(i - 9);
    endfunction
    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial i_clock = 1'b0;
    always #10 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            print_verdict();
        end
    end
    // Per-edge monitor of phases, strobes, fetches and writes
    always @(posedge i_clock) begin
        if (logging) begin
            check({o_phase_four, o_phase_three, o_phase_two, o_phase_one}
                === {ph_prev[2:0], ph_prev[3]}, "phase order");
            ph_prev = {ph_prev[2:0], ph_prev[3]};
            check(o_file_rd !== 1'b1 || o_phase_two === 1'b1, "rd phase");
            check(o_file_wr !== 1'b1 || o_phase_four === 1'b1, "wr phase");
            if (o_phase_four === 1'b1) begin
                addr_q.push_back(o_prog_addr);
                if (o_exec_valid === 1'b1 && o_instruction !== WORD_NOP) begin
                    word_q.push_back(o_instruction);
                end
            end
            if (o_file_wr === 1'b1) begin
                wr_q.push_back({o_file_addr, o_file_wdata});
            end
        end
    end

    task automatic run_test(input int n);
        logic [INSN_W-1:0]   pw [10];
        logic [14:0]         ew [4];
        logic [PC_MAX_W-1:0] t;
        logic [7:0]          k1;
        logic [7:0]          k2;
        logic [7:0]          fs;
        logic [4:0]          f1;
        logic [2:0]          b;
        logic [1:0]          p;
        seed = lfsr(seed);
        k1 = seed[7:0];
        k2 = seed[15:8];
        f1 = {2'b01, seed[18:16]};
        b = (n == 0) ? 3'h7 : seed[21:19];
        p = (n == 0) ? 2'b11 : seed[23:22];
        fs = {1'b0, seed[25:24], 2'b01, seed[28:26]};
        t = (n == 1) ? {p, 9'h0fd} : {p, 9'h1fd};
        @(posedge i_clock);
        logging <= 1'b0;
        i_rstn <= 1'b0;
        i_file_select <= fs;
        i_status_page <= p;
        i_carry <= seed[31];
        pw = '{{OP_MOVLW, k1}, {MOVWF_HI, f1}, WORD_CLRW,
            {OP_MOVF, 1'b0, f1}, {MOVWF_HI, f1 + 5'h08}, {OP_BSF, b, f1},
            (n == 1) ? {OP_CALL, 8'hfd} : {OP_JUMP, 9'h1fd},
            {OP_MOVLW, 8'hff}, {OP_MOVLW, k2},
            {MOVWF_HI, FILE_INDIRECT}};
        for (int i = 0; i < 2**PC_MAX_W; i++) begin
            cfe_mem_model_i.prog[i] = WORD_NOP;
        end
        for (int i = 0; i < 8; i++) begin
            cfe_mem_model_i.prog[i] = pw[i];
        end
        cfe_mem_model_i.prog[t] = pw[8];
        cfe_mem_model_i.prog[t + 11'h1] = pw[9];
        @(posedge i_clock);
        i_rstn <= 1'b1;
        #1;
        check(o_phase_one === 1'b1 && o_prog_addr === 11'h7ff, "reset");
        addr_q.delete();
        word_q.delete();
        wr_q.delete();
        ph_prev = 4'h8;
        logging = 1'b1;
        repeat (48) @(posedge i_clock);
        #1;
        for (int i = 0; i < 12; i++) begin
            check(addr_q[i] === exp_fetch(i, t), "fetch address");
        end
        for (int i = 0; i < 9; i++) begin
            check(word_q[i] === pw[i < 7 ? i : i + 1], "executed word");
        end
        ew = '{{fs[6:5], f1, k1}, {fs[6:5], f1 + 5'h08, k1},
            {fs[6:5], f1, k1 | (8'h01 << b)}, {fs[6:0], k2}};
        for (int i = 0; i < 4; i++) begin
            check(wr_q[i] === ew[i], "file write");
        end
        check(o_working === k2, "working register");
        $display("test %0d done", n);
    endtask

    initial begin
        i_rstn = 1'b0;
        i_file_select = 8'h00;
        i_status_page = 2'h0;
        i_carry = 1'b0;
        logging = 1'b0;
        n_fail = 0;
        num_checks = 0;
        cyc = 0;
        for (int n = 0; n < 3; n++) begin
            run_test(n);
        end
        print_verdict();
    end
endmodule
